// ### src/rwc_map.vh
// constants for the rheostat wiper and one-time store controller
`ifndef RWC_MAP_VH
`define RWC_MAP_VH

// serial frame layout: 16 bits, command in [13:10], data in [9:0]
`define RWC_CMD_MSB        13
`define RWC_CMD_LSB        10
`define RWC_DATA_MSB       9
`define RWC_LOC_MSB        5

// commands
`define RWC_CMD_NOP        4'h0
`define RWC_CMD_WR_WIPER   4'h1
`define RWC_CMD_RD_WIPER   4'h2
`define RWC_CMD_STORE      4'h3
`define RWC_CMD_SW_RESET   4'h4
`define RWC_CMD_RD_STORE   4'h5
`define RWC_CMD_RD_LAST    4'h6
`define RWC_CMD_WR_CTRL    4'h7
`define RWC_CMD_RD_CTRL    4'h8
`define RWC_CMD_SHUTDOWN   4'h9

// control register fields
`define RWC_CTRL_PROG_EN   0
`define RWC_CTRL_WR_EN     1
`define RWC_CTRL_CAL_DIS   2
`define RWC_CTRL_PROG_OK   3
`define RWC_CTRL_RESET     4'h0

// one-time store locations
`define RWC_LOC_FIRST      6'h01
`define RWC_LOC_LAST       6'h32
`define RWC_LOC_NONE       6'h00

// wiper
`define RWC_WIPER_MID      10'h200
`define RWC_EIGHT_BIT      1'b0

// 7-bit serial address, arbitrary value
`define RWC_DEV_ADDR       7'h2c

// internal programming cycle: least time, rounded up to cycles
`define RWC_CLK_NS         5
`define RWC_PROG_NS        20000
`define RWC_PROG_CYC       ((`RWC_PROG_NS + `RWC_CLK_NS - 1) / `RWC_CLK_NS)

`endif

// ### src/rwc_sync2.v
// two-flop synchroniser for asynchronous inputs
`timescale 1ns/1ps
`default_nettype none
module rwc_sync2 #(
    parameter W = 1
) (
    input  wire         clk_i,
    input  wire         rst_n_i,
    input  wire [W-1:0] async_i,
    output wire [W-1:0] sync_o
);
    reg [W-1:0] meta;
    reg [W-1:0] stable;

    // idle-high inputs, so reset to ones
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta   <= {W{1'b1}};
            stable <= {W{1'b1}};
        end else begin
            meta   <= async_i;
            stable <= meta;
        end
    end

    assign sync_o = stable;
endmodule // rwc_sync2
`default_nettype wire

// ### src/rwc_wiper_ctrl.v
// serial slave, wiper register, one-time store and shutdown control
`timescale 1ns/1ps
`default_nettype none
`include "rwc_map.vh"

// Contract
// - store locations are 6 bits; 0 is reserved, first value goes to 0x01
// - at most fifty values, last at 0x32; address bits above six ignored
// - each store with programming enabled and a free location starts an internal write cycle; new addresses not acknowledged meanwhile
// - address acknowledged during polling only once the write cycle ends
// - reset comes from command 4 or a low pulse on the reset pin
// - any reset loads wiper from most recently programmed location
// - with nothing programmed, reset loads wiper with midscale
// - calibration mode follows the calibration control bit
// - calibration is on after reset until software disables it
// - command 9 with data bit 0 set enters shutdown
// - in shutdown the A-to-wiper switch is open
// - every defined command still executes while in shutdown
// - command 9 with bit 0 clear, or any reset, leaves shutdown
// - wiper register decodes to one of 1024 or 256 taps
// - power-on sets midscale and empties the store, so the following restore keeps midscale
// - command 4 refreshes wiper from store, data bits ignored
// - command 5 reads the addressed location in the next frame
// - command 9 bit 0: one is shutdown, zero is normal
// - control bit 2 zero enables calibration, one disables it
module rwc_wiper_ctrl (
    input  wire          clk_i,
    input  wire          rst_n_i,
    input  wire          reset_pin_n_i,
    input  wire          scl_i,
    input  wire          sda_i,
    output reg           sda_o,
    output reg           sda_oe_o,
    output reg  [9:0]    wiper_o,
    output reg  [1023:0] tap_sel_o,
    output reg           a_switch_closed_o,
    output reg           cal_enable_o,
    output reg           shutdown_o,
    output reg           busy_o
);
    localparam ST_IDLE  = 3'd0;
    localparam ST_ADDR  = 3'd1;
    localparam ST_AACK  = 3'd2;
    localparam ST_WR    = 3'd3;
    localparam ST_WACK  = 3'd4;
    localparam ST_RD    = 3'd5;
    localparam ST_MACK  = 3'd6;

    localparam [15:0] PROG_CYC = `RWC_PROG_CYC;

    wire [2:0] pins_s;
    wire       rstpin_s;
    wire       scl_s;
    wire       sda_s;

    rwc_sync2 #(.W(3)) u_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .async_i ({reset_pin_n_i, scl_i, sda_i}),
        .sync_o  (pins_s)
    );
    assign rstpin_s = pins_s[2];
    assign scl_s    = pins_s[1];
    assign sda_s    = pins_s[0];

    reg        scl_q;
    reg        sda_q;
    reg        rstpin_q;
    reg [2:0]  state;
    reg [3:0]  bitcnt;
    reg [7:0]  shreg;
    reg [7:0]  txsh;
    reg        rd_dir;
    reg        byte_lo;
    reg        mnack;
    reg [7:0]  frame_hi;
    reg        cmd_valid;
    reg [15:0] cmd_word;

    reg [9:0]  wiper;
    reg [3:0]  ctrl;
    reg        shutdown;
    reg [5:0]  last_loc;
    reg [9:0]  otp_mem [0:63];
    reg [15:0] rd_word;
    reg [15:0] busy_cnt;
    reg        restore;
    integer    i;

    wire scl_rise = scl_s & ~scl_q;
    wire scl_fall = ~scl_s & scl_q;
    wire start_c  = scl_s & scl_q & sda_q & ~sda_s;
    wire stop_c   = scl_s & scl_q & ~sda_q & sda_s;
    wire busy     = (busy_cnt != 16'h0000);
    wire pin_rst  = rstpin_q & ~rstpin_s;

    wire [3:0] cmd  = cmd_word[`RWC_CMD_MSB:`RWC_CMD_LSB];
    wire [9:0] data = cmd_word[`RWC_DATA_MSB:0];
    wire [5:0] loc  = data[`RWC_LOC_MSB:0];
    wire [9:0] wr_val = `RWC_EIGHT_BIT ? {data[9:2], 2'b00} : data;
    wire [9:0] tap  = `RWC_EIGHT_BIT ? {2'b00, wiper[9:2]} : wiper;

    // serial slave: open drain, low driven by raising the enable
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            scl_q     <= 1'b1;
            sda_q     <= 1'b1;
            rstpin_q  <= 1'b1;
            state     <= ST_IDLE;
            bitcnt    <= 4'h0;
            shreg     <= 8'h00;
            txsh      <= 8'h00;
            rd_dir    <= 1'b0;
            byte_lo   <= 1'b0;
            mnack     <= 1'b0;
            frame_hi  <= 8'h00;
            cmd_valid <= 1'b0;
            cmd_word  <= 16'h0000;
            sda_o     <= 1'b0;
            sda_oe_o  <= 1'b0;
        end else begin
            scl_q     <= scl_s;
            sda_q     <= sda_s;
            rstpin_q  <= rstpin_s;
            cmd_valid <= 1'b0;
            sda_o     <= 1'b0;
            if (start_c) begin
                state    <= ST_ADDR;
                bitcnt   <= 4'h0;
                byte_lo  <= 1'b0;
                sda_oe_o <= 1'b0;
            end else if (stop_c) begin
                state    <= ST_IDLE;
                sda_oe_o <= 1'b0;
            end else if (scl_rise) begin
                case (state)
                    ST_ADDR, ST_WR: begin
                        shreg  <= {shreg[6:0], sda_s};
                        bitcnt <= bitcnt + 4'h1;
                    end
                    ST_RD: begin
                        bitcnt <= bitcnt + 4'h1;
                    end
                    ST_MACK: begin
                        mnack <= sda_s;
                    end
                    default: begin
                    end
                endcase
            end else if (scl_fall) begin
                case (state)
                    ST_ADDR: begin
                        if (bitcnt == 4'h8) begin
                            // withheld while programming, so host polling sees no ack
                            if (shreg[7:1] == `RWC_DEV_ADDR && !busy) begin
                                sda_oe_o <= 1'b1;
                                rd_dir   <= shreg[0];
                                state    <= ST_AACK;
                            end else begin
                                state <= ST_IDLE;
                            end
                        end
                    end
                    ST_AACK: begin
                        bitcnt <= 4'h0;
                        if (rd_dir) begin
                            txsh     <= {rd_word[14:8], 1'b0};
                            sda_oe_o <= ~rd_word[15];
                            byte_lo  <= 1'b1;
                            state    <= ST_RD;
                        end else begin
                            sda_oe_o <= 1'b0;
                            state    <= ST_WR;
                        end
                    end
                    ST_WR: begin
                        if (bitcnt == 4'h8) begin
                            sda_oe_o <= 1'b1;
                            state    <= ST_WACK;
                            byte_lo  <= ~byte_lo;
                            if (!byte_lo) begin
                                frame_hi <= shreg;
                            end else begin
                                cmd_word  <= {frame_hi, shreg};
                                cmd_valid <= 1'b1;
                            end
                        end
                    end
                    ST_WACK: begin
                        sda_oe_o <= 1'b0;
                        bitcnt   <= 4'h0;
                        state    <= ST_WR;
                    end
                    ST_RD: begin
                        if (bitcnt == 4'h8) begin
                            sda_oe_o <= 1'b0;
                            state    <= ST_MACK;
                        end else begin
                            sda_oe_o <= ~txsh[7];
                            txsh     <= {txsh[6:0], 1'b0};
                        end
                    end
                    ST_MACK: begin
                        bitcnt <= 4'h0;
                        if (mnack) begin
                            state <= ST_IDLE;
                        end else begin
                            // bytes alternate high, low, high while the host acks
                            txsh     <= byte_lo ? {rd_word[6:0], 1'b0} : {rd_word[14:8], 1'b0};
                            sda_oe_o <= byte_lo ? ~rd_word[7] : ~rd_word[15];
                            byte_lo  <= ~byte_lo;
                            state    <= ST_RD;
                        end
                    end
                    default: begin
                        state <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // command execution; shutdown does not gate it
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wiper    <= `RWC_WIPER_MID;
            restore  <= 1'b1;
            ctrl     <= `RWC_CTRL_RESET;
            shutdown <= 1'b0;
            last_loc <= `RWC_LOC_NONE;
            rd_word  <= 16'h0000;
            busy_cnt <= 16'h0000;
            for (i = 0; i < 64; i = i + 1) begin
                otp_mem[i] <= 10'h000;
            end
        end else begin
            if (busy) begin
                busy_cnt <= busy_cnt - 16'h0001;
            end
            if (restore) begin
                restore <= 1'b0;
                if (last_loc == `RWC_LOC_NONE) begin
                    wiper <= `RWC_WIPER_MID;
                end else begin
                    wiper <= otp_mem[last_loc];
                end
            end
            if (pin_rst) begin
                restore  <= 1'b1;
                shutdown <= 1'b0;
                ctrl     <= {ctrl[`RWC_CTRL_PROG_OK], 3'b000};
            end else if (cmd_valid) begin
                case (cmd)
                    `RWC_CMD_WR_WIPER: begin
                        if (ctrl[`RWC_CTRL_WR_EN]) begin
                            wiper <= wr_val;
                        end
                    end
                    `RWC_CMD_RD_WIPER: begin
                        rd_word <= {6'h00, wiper};
                    end
                    `RWC_CMD_STORE: begin
                        if (ctrl[`RWC_CTRL_PROG_EN] && last_loc != `RWC_LOC_LAST) begin
                            otp_mem[last_loc + `RWC_LOC_FIRST] <= wiper;
                            last_loc <= last_loc + `RWC_LOC_FIRST;
                            busy_cnt <= PROG_CYC;
                            ctrl[`RWC_CTRL_PROG_OK] <= 1'b1;
                        end else begin
                            ctrl[`RWC_CTRL_PROG_OK] <= 1'b0;
                        end
                    end
                    `RWC_CMD_SW_RESET: begin
                        restore  <= 1'b1;
                        shutdown <= 1'b0;
                        ctrl     <= {ctrl[`RWC_CTRL_PROG_OK], 3'b000};
                    end
                    `RWC_CMD_RD_STORE: begin
                        // reserved and unused locations read back zero
                        if (loc == `RWC_LOC_NONE || loc > `RWC_LOC_LAST) begin
                            rd_word <= 16'h0000;
                        end else begin
                            rd_word <= {6'h00, otp_mem[loc]};
                        end
                    end
                    `RWC_CMD_RD_LAST: begin
                        rd_word <= {10'h000, last_loc};
                    end
                    `RWC_CMD_WR_CTRL: begin
                        ctrl[2:0] <= data[2:0];
                    end
                    `RWC_CMD_RD_CTRL: begin
                        rd_word <= {12'h000, ctrl};
                    end
                    `RWC_CMD_SHUTDOWN: begin
                        shutdown <= data[0];
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // registered outputs
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wiper_o           <= `RWC_WIPER_MID;
            tap_sel_o         <= {1024{1'b0}};
            a_switch_closed_o <= 1'b0;
            cal_enable_o      <= 1'b1;
            shutdown_o        <= 1'b0;
            busy_o            <= 1'b0;
        end else begin
            wiper_o           <= wiper;
            tap_sel_o         <= {{1023{1'b0}}, 1'b1} << tap;
            a_switch_closed_o <= ~shutdown;
            cal_enable_o      <= ~ctrl[`RWC_CTRL_CAL_DIS];
            shutdown_o        <= shutdown;
            busy_o            <= busy;
        end
    end
endmodule // rwc_wiper_ctrl
`default_nettype wire

// ### sim/rwc_wiper_chk.sv
// port assertions for the wiper controller
`timescale 1ns/1ps
`default_nettype none
`include "rwc_map.vh"
module rwc_wiper_chk (
    input wire logic          clk_i,
    input wire logic          rst_n_i,
    input wire logic          reset_pin_n_i,
    input wire logic          scl_i,
    input wire logic          sda_i,
    input wire logic          sda_o,
    input wire logic          sda_oe_o,
    input wire logic [9:0]    wiper_o,
    input wire logic [1023:0] tap_sel_o,
    input wire logic          a_switch_closed_o,
    input wire logic          cal_enable_o,
    input wire logic          shutdown_o,
    input wire logic          busy_o
);
    localparam int PROG = `RWC_PROG_CYC;
    int busy_cnt;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // counts the programming cycle, too long for a repetition
    always_ff @(posedge clk_i or negedge rst_n_i)
        if (!rst_n_i)
            busy_cnt <= 0;
        else
            busy_cnt <= busy_o ? busy_cnt + 1 : 0;
    sequence pin_fall;
        $fell(reset_pin_n_i);
    endsequence
    sequence shut_gone;
        ##[1:10] !shutdown_o;
    endsequence
    shut_open_a: assert property (shutdown_o |-> ##[0:1] !a_switch_closed_o)
        else $error("switch closed in shutdown");
    busy_len_a: assert property ($fell(busy_o) |-> busy_cnt == PROG)
        else $error("programming cycle length wrong");
    busy_max_a: assert property (busy_cnt <= PROG)
        else $error("programming cycle overran");
    // ack of the closing byte may still stand as busy rises
    busy_quiet_a: assert property (busy_o && $past(busy_o, 64) |-> !sda_oe_o)
        else $error("answer while programming");
    mid_reset_a: assert property ($rose(rst_n_i) |-> wiper_o == `RWC_WIPER_MID)
        else $error("wiper not midscale at power-on");
    cal_reset_a: assert property ($rose(rst_n_i) |-> cal_enable_o && !shutdown_o)
        else $error("bad state after power-on");
    // tap decode lands on the same edge as the wiper output
    tap_dec_a: assert property ($past(rst_n_i, 2) |->
        tap_sel_o == (1024'h1 << (`RWC_EIGHT_BIT ? wiper_o[9:2] : wiper_o)))
        else $error("tap decode wrong");
    pin_exit_a: assert property (pin_fall |-> shut_gone)
        else $error("pin reset left shutdown on");
endmodule // rwc_wiper_chk
bind rwc_wiper_ctrl rwc_wiper_chk u_chk (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .reset_pin_n_i(reset_pin_n_i),
    .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .wiper_o(wiper_o), .tap_sel_o(tap_sel_o), .a_switch_closed_o(a_switch_closed_o),
    .cal_enable_o(cal_enable_o), .shutdown_o(shutdown_o), .busy_o(busy_o)
);
`default_nettype wire

// ### sim/rwc_host.sv
// serial host model issuing wiper and store commands
`timescale 1ns/1ps
`default_nettype none
`include "rwc_map.vh"
module rwc_host (
    input  wire logic clk_i,
    input  wire logic sda_i,
    output var  logic scl_o,
    output var  logic pull_o
);
    // half period in clocks, well above the 2-flop input delay
    localparam int H = 8;
    initial begin
        scl_o = 1'b1;
        pull_o = 1'b0;
    end
    task automatic hw(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    // data moves only after scl has been low a while, never near a start or stop
    task automatic bit_x(input logic b, output logic r);
        hw(2);
        pull_o = ~b;
        hw(H);
        scl_o = 1'b1;
        hw(H);
        r = sda_i;
        scl_o = 1'b0;
    endtask
    task automatic st;
        hw(H);
        pull_o = 1'b1;
        hw(H);
        scl_o = 1'b0;
    endtask
    task automatic sp;
        hw(2);
        pull_o = 1'b1;
        hw(H);
        scl_o = 1'b1;
        hw(H);
        pull_o = 1'b0;
        hw(H);
    endtask
    task automatic bt(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_x(d[i], r);
        bit_x(1'b1, r);
        ack = ~r;
    endtask
    task automatic rb(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_x(1'b1, d[i]);
        bit_x(last, r);
    endtask
    task automatic wr(input logic [3:0] c, input logic [9:0] d, output logic a);
        logic x;
        st();
        bt({`RWC_DEV_ADDR, 1'b0}, a);
        if (a) begin
            bt({2'b00, c, d[9:8]}, x);
            bt(d[7:0], x);
        end
        sp();
    endtask
    task automatic rd(output logic [15:0] w);
        logic a;
        st();
        bt({`RWC_DEV_ADDR, 1'b1}, a);
        rb(1'b0, w[15:8]);
        rb(1'b1, w[7:0]);
        sp();
    endtask
    task automatic poll(output logic a);
        st();
        bt({`RWC_DEV_ADDR, 1'b0}, a);
        sp();
    endtask
endmodule // rwc_host
`default_nettype wire

// ### sim/testbench.sv
// self-checking bench for the wiper controller
`timescale 1ns/1ps
`default_nettype none
`include "rwc_map.vh"
module testbench;
    logic          clk = 1'b0;
    logic          rst_n = 1'b0;
    logic          pin_n = 1'b1;
    wire           scl;
    wire           pull;
    wire           sda;
    wire           sda_o;
    wire           sda_oe;
    wire           sw;
    wire           cal;
    wire           shut;
    wire           busy;
    wire [9:0]     wiper;
    wire [1023:0]  tap;
    int            err_count = 0;
    int            checks_done = 0;
    // open drain line with pull-up
    assign sda = ~(pull | (sda_oe & ~sda_o));
    always #2.5 clk = ~clk;
    rwc_wiper_ctrl uut (.clk_i(clk), .rst_n_i(rst_n), .reset_pin_n_i(pin_n), .scl_i(scl),
        .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe), .wiper_o(wiper), .tap_sel_o(tap),
        .a_switch_closed_o(sw), .cal_enable_o(cal), .shutdown_o(shut), .busy_o(busy));
    rwc_host host (.clk_i(clk), .sda_i(sda), .scl_o(scl), .pull_o(pull));
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
        checks_done++;
        if (s !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic cmd(input logic [3:0] c, input logic [9:0] d);
        logic a;
        host.wr(c, d, a);
        chk("addr ack", 16'(a), 16'h1);
        repeat (4) @(negedge clk);
    endtask
    task automatic rdw(input string n, input logic [15:0] e);
        logic [15:0] w;
        host.rd(w);
        chk(n, w, e);
    endtask
    task automatic t_power;
        chk("wiper", 16'(wiper), 16'h0200);
        chk("cal", 16'(cal), 16'h1);
        chk("switch", 16'(sw), 16'h1);
        chk("sda level", 16'(sda_o), 16'h0);
        cmd(`RWC_CMD_RD_WIPER, 10'h000);
        rdw("rd wiper", 16'h0200);
        cmd(`RWC_CMD_WR_CTRL, 10'h003);
        cmd(`RWC_CMD_WR_WIPER, 10'h100);
        chk("wiper", 16'(wiper), 16'h0100);
        chk("tap", 16'(tap[256]), 16'h1);
        $display("test power done");
    endtask
    task automatic t_store;
        logic a;
        int n;
        cmd(`RWC_CMD_STORE, 10'h000);
        chk("busy", 16'(busy), 16'h1);
        host.poll(a);
        chk("busy nack", 16'(a), 16'h0);
        n = 0;
        while (!a && n < 100) begin
            host.poll(a);
            n++;
        end
        if (!a) begin
            err_count++;
            $display("CHECK FAILED poll expected 1 seen 0");
            complete_run();
        end
        chk("busy end", 16'(busy), 16'h0);
        cmd(`RWC_CMD_RD_LAST, 10'h000);
        rdw("last loc", 16'h0001);
        cmd(`RWC_CMD_RD_STORE, 10'h041);
        rdw("loc 1", 16'h0100);
        cmd(`RWC_CMD_RD_STORE, 10'h000);
        rdw("loc 0", 16'h0000);
        $display("test store done");
    endtask
    task automatic t_shut;
        cmd(`RWC_CMD_WR_WIPER, 10'h3ff);
        cmd(`RWC_CMD_SW_RESET, 10'h3ff);
        chk("sw reset", 16'(wiper), 16'h0100);
        cmd(`RWC_CMD_SHUTDOWN, 10'h001);
        chk("shut", 16'(shut), 16'h1);
        chk("open", 16'(sw), 16'h0);
        cmd(`RWC_CMD_WR_CTRL, 10'h003);
        cmd(`RWC_CMD_WR_WIPER, 10'h055);
        chk("wiper shut", 16'(wiper), 16'h0055);
        cmd(`RWC_CMD_NOP, 10'h3ff);
        chk("nop shut", 16'(wiper), 16'h0055);
        cmd(`RWC_CMD_SHUTDOWN, 10'h3fe);
        chk("normal", 16'(shut), 16'h0);
        chk("closed", 16'(sw), 16'h1);
        cmd(`RWC_CMD_SHUTDOWN, 10'h001);
        cmd(`RWC_CMD_SW_RESET, 10'h000);
        chk("sw exit", 16'(shut), 16'h0);
        cmd(`RWC_CMD_SHUTDOWN, 10'h001);
        pin_n = 1'b0;
        repeat (4) @(negedge clk);
        pin_n = 1'b1;
        repeat (10) @(negedge clk);
        chk("pin exit", 16'(shut), 16'h0);
        chk("pin wiper", 16'(wiper), 16'h0100);
        $display("test shutdown done");
    endtask
    task automatic t_cal;
        cmd(`RWC_CMD_WR_CTRL, 10'h004);
        chk("cal off", 16'(cal), 16'h0);
        cmd(`RWC_CMD_RD_CTRL, 10'h000);
        rdw("ctrl rd", 16'h000c);
        cmd(`RWC_CMD_WR_CTRL, 10'h000);
        chk("cal on", 16'(cal), 16'h1);
        // power-on empties the store, so reset falls back to midscale
        rst_n = 1'b0;
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        repeat (5) @(negedge clk);
        cmd(`RWC_CMD_WR_CTRL, 10'h003);
        cmd(`RWC_CMD_WR_WIPER, 10'h0ff);
        cmd(`RWC_CMD_SW_RESET, 10'h000);
        chk("empty", 16'(wiper), 16'h0200);
        $display("test calibration done");
    endtask
    initial begin
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        repeat (5) @(negedge clk);
        t_power();
        t_store();
        t_shut();
        t_cal();
        complete_run();
    end
endmodule // testbench
`default_nettype wire
